/* core/pssub_consts.vh */
// Constants for the packed signed saturating subtract unit
`ifndef PSSUB_CONSTS_VH
`define PSSUB_CONSTS_VH

`define PSSUB_MAJOR_LSB 26
`define PSSUB_MAJOR_MSB 31
`define PSSUB_RS_LSB 21
`define PSSUB_RS_MSB 25
`define PSSUB_RT_LSB 16
`define PSSUB_RT_MSB 20
`define PSSUB_RD_LSB 11
`define PSSUB_RD_MSB 15
`define PSSUB_FUNC_LSB 6
`define PSSUB_FUNC_MSB 10
`define PSSUB_MINOR_LSB 0
`define PSSUB_MINOR_MSB 5

`define PSSUB_MULTIMEDIA_MAJOR_OPCODE 6'h1c
`define PSSUB_MULTIMEDIA_MINOR_GROUP_ZERO 6'h08
`define PSSUB_FUNC_SUB_SAT_HALF 5'h15
`define PSSUB_FUNC_SUB_SAT_WORD 5'h11

`define PSSUB_HALF_MAX 16'h7fff
`define PSSUB_HALF_MIN 16'h8000
`define PSSUB_WORD_MAX 32'h7fff_ffff
`define PSSUB_WORD_MIN 32'h8000_0000

`endif

/* core/pssub_lane.v */
// One signed saturating subtract lane
`include "pssub_consts.vh"

module pssub_lane #(
  parameter W = 16
) (
  input wire [W-1:0] a,
  input wire [W-1:0] b,
  input wire [W-1:0] sat_max,
  input wire [W-1:0] sat_min,
  output reg [W-1:0] y
);

  wire [W:0] diff;

  // One extra bit holds the true signed difference
  assign diff = {a[W-1], a} - {b[W-1], b};

  always @* begin
    if (diff[W] != diff[W-1]) begin
      // Clamp by the true sign; no overflow flag leaves the lane
      y = diff[W] ? sat_min : sat_max;
    end else begin
      y = diff[W-1:0];
    end
  end

endmodule

/* core/pssub_unit.v */
// Packed signed saturating subtract datapath, halfword and word variants
`include "pssub_consts.vh"

// Notes on behaviour
// RULE1: Halfword op subtracts eight signed 16-bit rt lanes from rs lanes in place.
// RULE2: Halfword lanes clamp to 0x7FFF above range, 0x8000 below, else low bits.
// RULE3: Word op subtracts four signed 32-bit rt lanes from rs lanes in place.
// RULE4: Word lanes clamp to 0x7FFFFFFF above, 0x80000000 below, else low bits.
// RULE5: No overflow or underflow exception is ever raised.
// RULE6: Full 128-bit sources are read; all destination lanes are written.
// RULE7: Halfword op is major 011100, function 10101, minor 001000.
// RULE8: Word op is function 10001, minor 001000, same major and fields.
// RULE9: Lane arithmetic is combinational; result is registered for write-back.
module pssub_unit (
  input wire clk_sys,
  input wire nrst,
  input wire issue_valid,
  input wire [31:0] instr_word,
  input wire [127:0] src_rs,
  input wire [127:0] src_rt,
  output reg result_valid_r,
  output reg [127:0] result_r,
  output reg [4:0] dest_reg_r,
  output reg op_half_r,
  output reg op_word_r,
  output reg exception_r
);

  // ************************************************************
  // Decode
  // ************************************************************
  wire [5:0] major_fld;
  wire [4:0] func_fld;
  wire [5:0] minor_fld;
  wire group_hit;
  wire is_half;
  wire is_word;
  wire take_op;
  wire [4:0] rd_fld;

  assign major_fld = instr_word[`PSSUB_MAJOR_MSB:`PSSUB_MAJOR_LSB];
  assign func_fld = instr_word[`PSSUB_FUNC_MSB:`PSSUB_FUNC_LSB];
  assign minor_fld = instr_word[`PSSUB_MINOR_MSB:`PSSUB_MINOR_LSB];
  assign group_hit = (major_fld == `PSSUB_MULTIMEDIA_MAJOR_OPCODE) &&
                     (minor_fld == `PSSUB_MULTIMEDIA_MINOR_GROUP_ZERO);
  assign is_half = group_hit && (func_fld == `PSSUB_FUNC_SUB_SAT_HALF); // RULE7
  assign is_word = group_hit && (func_fld == `PSSUB_FUNC_SUB_SAT_WORD); // RULE8
  assign take_op = issue_valid && (is_half || is_word);
  assign rd_fld = instr_word[`PSSUB_RD_MSB:`PSSUB_RD_LSB];

  // ************************************************************
  // Lanes
  // ************************************************************
  wire [127:0] half_res;
  wire [127:0] word_res;
  reg [127:0] lane_res;

  pssub_lane #(
    .W(16)
  ) u_half_0 ( // RULE1
    .a(src_rs[15:0]),
    .b(src_rt[15:0]),
    .sat_max(`PSSUB_HALF_MAX), // RULE2
    .sat_min(`PSSUB_HALF_MIN),
    .y(half_res[15:0])
  );

  pssub_lane #(
    .W(16)
  ) u_half_1 ( // RULE1
    .a(src_rs[31:16]),
    .b(src_rt[31:16]),
    .sat_max(`PSSUB_HALF_MAX), // RULE2
    .sat_min(`PSSUB_HALF_MIN),
    .y(half_res[31:16])
  );

  pssub_lane #(
    .W(16)
  ) u_half_2 ( // RULE1
    .a(src_rs[47:32]),
    .b(src_rt[47:32]),
    .sat_max(`PSSUB_HALF_MAX), // RULE2
    .sat_min(`PSSUB_HALF_MIN),
    .y(half_res[47:32])
  );

  pssub_lane #(
    .W(16)
  ) u_half_3 ( // RULE1
    .a(src_rs[63:48]),
    .b(src_rt[63:48]),
    .sat_max(`PSSUB_HALF_MAX), // RULE2
    .sat_min(`PSSUB_HALF_MIN),
    .y(half_res[63:48])
  );

  pssub_lane #(
    .W(16)
  ) u_half_4 ( // RULE1
    .a(src_rs[79:64]),
    .b(src_rt[79:64]),
    .sat_max(`PSSUB_HALF_MAX), // RULE2
    .sat_min(`PSSUB_HALF_MIN),
    .y(half_res[79:64])
  );

  pssub_lane #(
    .W(16)
  ) u_half_5 ( // RULE1
    .a(src_rs[95:80]),
    .b(src_rt[95:80]),
    .sat_max(`PSSUB_HALF_MAX), // RULE2
    .sat_min(`PSSUB_HALF_MIN),
    .y(half_res[95:80])
  );

  pssub_lane #(
    .W(16)
  ) u_half_6 ( // RULE1
    .a(src_rs[111:96]),
    .b(src_rt[111:96]),
    .sat_max(`PSSUB_HALF_MAX), // RULE2
    .sat_min(`PSSUB_HALF_MIN),
    .y(half_res[111:96])
  );

  pssub_lane #(
    .W(16)
  ) u_half_7 ( // RULE1
    .a(src_rs[127:112]),
    .b(src_rt[127:112]),
    .sat_max(`PSSUB_HALF_MAX), // RULE2
    .sat_min(`PSSUB_HALF_MIN),
    .y(half_res[127:112])
  );

  pssub_lane #(
    .W(32)
  ) u_word_0 ( // RULE3
    .a(src_rs[31:0]),
    .b(src_rt[31:0]),
    .sat_max(`PSSUB_WORD_MAX), // RULE4
    .sat_min(`PSSUB_WORD_MIN),
    .y(word_res[31:0])
  );

  pssub_lane #(
    .W(32)
  ) u_word_1 ( // RULE3
    .a(src_rs[63:32]),
    .b(src_rt[63:32]),
    .sat_max(`PSSUB_WORD_MAX), // RULE4
    .sat_min(`PSSUB_WORD_MIN),
    .y(word_res[63:32])
  );

  pssub_lane #(
    .W(32)
  ) u_word_2 ( // RULE3
    .a(src_rs[95:64]),
    .b(src_rt[95:64]),
    .sat_max(`PSSUB_WORD_MAX), // RULE4
    .sat_min(`PSSUB_WORD_MIN),
    .y(word_res[95:64])
  );

  pssub_lane #(
    .W(32)
  ) u_word_3 ( // RULE3
    .a(src_rs[127:96]),
    .b(src_rt[127:96]),
    .sat_max(`PSSUB_WORD_MAX), // RULE4
    .sat_min(`PSSUB_WORD_MIN),
    .y(word_res[127:96])
  );

  always @* begin
    // Every lane of the destination comes from the selected variant
    if (is_word) begin
      lane_res = word_res; // RULE6
    end else begin
      lane_res = half_res; // RULE6
    end
  end

  // ************************************************************
  // Write-back stage
  // ************************************************************
  reg result_valid_nxt;
  reg op_half_nxt;
  reg op_word_nxt;
  reg exception_nxt;
  reg [4:0] dest_reg_nxt;
  reg [127:0] result_nxt;

  always @* begin
    // A refused or idle cycle leaves the last result for the register file
    result_valid_nxt = 1'h0;
    op_half_nxt = 1'h0;
    op_word_nxt = 1'h0;
    exception_nxt = 1'h0; // RULE5
    dest_reg_nxt = dest_reg_r;
    result_nxt = result_r;
    if (take_op) begin
      result_valid_nxt = 1'h1; // RULE9
      op_half_nxt = is_half;
      op_word_nxt = is_word;
      dest_reg_nxt = rd_fld;
      result_nxt = lane_res; // RULE6
    end
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      result_valid_r <= 1'h0;
      result_r <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      dest_reg_r <= 5'h00;
      op_half_r <= 1'h0;
      op_word_r <= 1'h0;
      exception_r <= 1'h0;
    end else begin
      result_valid_r <= result_valid_nxt;
      result_r <= result_nxt; // RULE9
      dest_reg_r <= dest_reg_nxt;
      op_half_r <= op_half_nxt;
      op_word_r <= op_word_nxt;
      exception_r <= exception_nxt;
    end
  end

endmodule

/* verif/pssub_rf.sv */
// Register file model feeding the unit
module pssub_rf (
  input wire [31:0] instr_word,
  output wire [127:0] src_rs,
  output wire [127:0] src_rt
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [127:0] R = 128'h7fff_8000_3fff_c000_4000_0000_8000_1234;
  assign src_rs = instr_word[21] ? R : ~R;
  assign src_rt = instr_word[16] ? R : ~R;
endmodule

/* verif/pssub_unit_asserts.sv */
// Port checker for the unit
module pssub_unit_asserts (
  input wire clk_sys,
  input wire nrst,
  input wire issue_valid,
  input wire [31:0] instr_word,
  input wire [127:0] src_rs,
  input wire [127:0] src_rt,
  input wire result_valid_r,
  input wire [127:0] result_r,
  input wire [4:0] dest_reg_r,
  input wire op_half_r,
  input wire op_word_r,
  input wire exception_r
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [16:0] k = {instr_word[31:26], instr_word[10:0]};
  wire hv = issue_valid && k == 17'h0_e548;
  wire wv = issue_valid && k == 17'h0_e448;
  wire t = hv || wv;
  wire [32:0] w0_diff = {src_rs[31], src_rs[31:0]} - {src_rt[31], src_rt[31:0]};
  wire [32:0] w2_diff = {src_rs[95], src_rs[95:64]} - {src_rt[95], src_rt[95:64]};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  take_pulse_a: assert property (t |=> result_valid_r) else $error("miss");
  half_flag_a: assert property (hv |=> op_half_r) else $error("half");
  word_flag_a: assert property (wv |=> op_word_r) else $error("word");
  no_exc_a: assert property (!exception_r) else $error("exc");
  refuse_hold_a: assert property (!t |=> !result_valid_r && $stable(result_r))
    else $error("hold");
  dest_field_a: assert property (t |=> dest_reg_r == $past(instr_word[15:11]))
    else $error("dest");
  one_kind_a: assert property (result_valid_r |-> op_half_r ^ op_word_r)
    else $error("kind");
  half_sat_a: assert property (hv && !src_rs[127] && src_rt[127:112] == 16'h8000
    |=> result_r[127:112] == 16'h7fff) else $error("sat");
  word_sat_a: assert property (wv && w0_diff[32] && !w0_diff[31]
    |=> result_r[31:0] == 32'h8000_0000) else $error("word sat");
  word_lane_a: assert property (wv && (w2_diff[32] == w2_diff[31])
    |=> result_r[95:64] == $past(w2_diff[31:0])) else $error("word lane");
endmodule
bind pssub_unit pssub_unit_asserts chk (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .issue_valid(issue_valid),
  .instr_word(instr_word),
  .src_rs(src_rs),
  .src_rt(src_rt),
  .result_valid_r(result_valid_r),
  .result_r(result_r),
  .dest_reg_r(dest_reg_r),
  .op_half_r(op_half_r),
  .op_word_r(op_word_r),
  .exception_r(exception_r)
);

/* verif/parallel_signed_sat_subtract_bench.sv */
// Bench for the subtract unit
module parallel_signed_sat_subtract_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] half_a = {6'h1c, 5'h01, 5'h02, 5'h0a, 5'h15, 6'h08};
  localparam logic [31:0] half_b = {6'h1c, 5'h02, 5'h01, 5'h1f, 5'h15, 6'h08};
  localparam logic [31:0] word_a = {6'h1c, 5'h01, 5'h02, 5'h0a, 5'h11, 6'h08};
  localparam logic [31:0] word_b = {6'h1c, 5'h02, 5'h01, 5'h1f, 5'h11, 6'h08};
  localparam logic [31:0] bad_func = {6'h1c, 5'h01, 5'h02, 5'h0a, 5'h19, 6'h08};
  localparam logic [31:0] bad_minor = {6'h1c, 5'h01, 5'h02, 5'h0a, 5'h15, 6'h28};
  localparam logic [31:0] bad_major = {6'h1d, 5'h01, 5'h02, 5'h0a, 5'h15, 6'h08};
  localparam logic [127:0] hres_a = 128'h7fff_8000_7fff_8001_7fff_0001_8000_2469;
  localparam logic [127:0] hres_b = 128'h8000_7fff_8001_7fff_8000_ffff_7fff_db97;
  localparam logic [127:0] wres_a = 128'h7fff_ffff_7fff_8001_7fff_ffff_8000_0000;
  localparam logic [127:0] wres_b = 128'h8000_0000_8000_7fff_8000_0000_7fff_ffff;
  logic clk_sys = 1'h0, nrst = 1'h0, issue_valid = 1'h0;
  logic [31:0] instr_word = 32'h0000_0000;
  wire [127:0] src_rs, src_rt, result_r;
  wire [4:0] dest_reg_r;
  wire result_valid_r, op_half_r, op_word_r, exception_r;
  int errors = 0, samples_checked = 0;
  always #2 clk_sys = ~clk_sys;
  pssub_rf rf (
    .instr_word(instr_word),
    .src_rs(src_rs),
    .src_rt(src_rt)
  );
  pssub_unit uut (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .issue_valid(issue_valid),
    .instr_word(instr_word),
    .src_rs(src_rs),
    .src_rt(src_rt),
    .result_valid_r(result_valid_r),
    .result_r(result_r),
    .dest_reg_r(dest_reg_r),
    .op_half_r(op_half_r),
    .op_word_r(op_word_r),
    .exception_r(exception_r)
  );
  wire [136:0] outs;
  assign outs = {result_valid_r, op_half_r, op_word_r, exception_r, dest_reg_r, result_r};
  task automatic check(input logic [136:0] got, input logic [136:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [31:0] iw, input logic v, input logic [136:0] exp);
    @(posedge clk_sys);
    issue_valid <= v;
    instr_word <= iw;
    @(posedge clk_sys);
    #1;
    check(outs, exp);
  endtask
  task automatic t_half;
    op(half_a, 1'h1, {4'hc, 5'h0a, hres_a});
    op(half_b, 1'h1, {4'hc, 5'h1f, hres_b});
  endtask
  task automatic t_word;
    op(word_a, 1'h1, {4'ha, 5'h0a, wres_a});
    op(word_b, 1'h1, {4'ha, 5'h1f, wres_b});
  endtask
  task automatic t_refuse;
    op(bad_func, 1'h1, {4'h0, 5'h1f, wres_b});
    op(bad_minor, 1'h1, {4'h0, 5'h1f, wres_b});
    op(bad_major, 1'h1, {4'h0, 5'h1f, wres_b});
    op(word_a, 1'h0, {4'h0, 5'h1f, wres_b});
  endtask
  task automatic t_back;
    @(posedge clk_sys);
    issue_valid <= 1'h1;
    instr_word <= half_a;
    @(posedge clk_sys);
    instr_word <= word_a;
    #1;
    check(outs, {4'hc, 5'h0a, hres_a});
    @(posedge clk_sys);
    issue_valid <= 1'h0;
    #1;
    check(outs, {4'ha, 5'h0a, wres_a});
    @(posedge clk_sys);
    #1;
    check(outs, {4'h0, 5'h0a, wres_a});
  endtask
  task automatic t_reset;
    @(posedge clk_sys);
    nrst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    check(outs, 137'h0);
    @(posedge clk_sys);
    nrst <= 1'h1;
    op(half_a, 1'h1, {4'hc, 5'h0a, hres_a});
  endtask
  task automatic finish_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'h1;
    t_half;
    t_word;
    t_refuse;
    t_back;
    t_reset;
    finish_test;
  end
endmodule
